// ### hw/ext_serial_codec.v
// extended serial transceiver with manchester framing and long characters
`timescale 1ns/100ps
// What this block does
// - parity is data xor, inverted for odd
// - parity sits between data and stop
// - no parity in manchester mode
// - one is low half then high
// - zero is high half then low
// - manchester start bit is fixed one
// - stop bits are level coded
// - separate rx and tx character sizes
// - receiver bit order selectable
// - decoder runs with manchester and rx enable
// - seventeenth bit edge makes long frame
// - sixteen bit counter limited by period
// - period sets window and overflow limit
// - mid-bit edge captures half count
// - count to zero, half opens window
// - missing edge raises manchester frame error
// - frame error also sets receive complete
// - after error restart start detection
// - transmit enable takes the output pin
// - high buffer first, low write starts
// - tx disable waits for empty path
// - extensions gated by extension enable, except tx two stop bits
module ext_serial_codec #(
	parameter PERIOD_W = 16
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        serial_in_pin,
	output reg         serial_out_pin,
	output reg         serial_out_en,
	output reg         receive_complete_flag
);
`include "ext_serial_regs.vh"
localparam TX_IDLE = 2'd0, TX_START = 2'd1, TX_BITS = 2'd2, TX_STOP = 2'd3;
localparam RX_HUNT = 2'd0, RX_BITS = 2'd1, RX_STOP = 2'd2;

reg  [7:0]  size_ctrl;
reg  [7:0]  ext_control_b;
reg  [7:0]  serial_control_b;
reg  [15:0] manchester_period;
reg  [7:0]  low_tx, high_tx;
reg         ninth_bit_holder;
reg         tx_full;
reg  [7:0]  low_rx, high_rx;
reg         rx_bit17;
reg         manchester_frame_error, long_frame_flag, level_frame_error;
reg         overrun, parity_err;
reg  [1:0]  stop_vals;
reg  [2:0]  in_sync;
reg         rx_level;
reg         tx_active_en;
// tx datapath
reg  [1:0]  tx_state;
reg  [16:0] tx_shift;
reg  [4:0]  tx_left;
reg         tx_parity;
reg         tx_par_phase;
reg  [1:0]  tx_stop_left;
reg  [15:0] tx_cnt;
// rx datapath
reg  [1:0]  rx_state;
reg  [16:0] rx_shift;
reg  [4:0]  rx_got;
reg  [15:0] dec_cnt;
reg  [15:0] half_cnt;
reg         dec_down;
reg         dec_prev;
reg         rx_parity;
reg  [1:0]  rx_stop_idx;

wire        wr = psel & penable & pwrite;
wire        rd = psel & penable & ~pwrite;
wire        ext_on = ext_control_b[`EXT_ENABLE];
wire        manch = ext_on & ext_control_b[`EXT_MANCHESTER];
wire [1:0]  par_mode = manch ? 2'b00 :
	serial_control_b[`CB_PAR_HI:`CB_PAR_LO];
wire        rx_on = serial_control_b[`CB_RX_ENABLE];
wire        dec_on = manch & rx_on;

function [4:0] char_bits;
	input [3:0] code;
	input       ext;
	begin
		if (!ext)
			char_bits = {3'b000, code[1:0]} + 5'd5;
		else case (code)
		4'h0, 4'h1, 4'h2, 4'h3: char_bits = {3'b000, code[1:0]} + 5'd5;
		4'h7: char_bits = 5'd9;
		4'h8, 4'h9, 4'hA, 4'hB: char_bits = {3'b000, code[1:0]} + 5'd13;
		4'hF: char_bits = 5'd17;
		default: char_bits = 5'd8;
		endcase
	end
endfunction

wire [4:0]  tx_len = char_bits(size_ctrl[7:4], ext_on);
wire [4:0]  rx_len_cfg = char_bits(size_ctrl[3:0], ext_on);
wire        long_mode = manch & ext_control_b[`EXT_LONG_MODE] &
	(rx_len_cfg == 5'd16);
wire [4:0]  rx_len = long_mode ? 5'd17 : rx_len_cfg;
wire [16:0] tx_word = {ninth_bit_holder, high_tx, low_tx};
wire [16:0] tx_mask = (17'h1FFFF >> (5'd17 - tx_len));
wire [15:0] bit_time = manchester_period;
wire        tx_half = (tx_cnt < {1'b0, bit_time[15:1]});
wire        tx_tick = (tx_cnt == 16'h0000);

// three-stage input sync; change accepted when stages two and three agree
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		in_sync  <= 3'b111;
		rx_level <= 1'b1;
	end else begin
		in_sync <= {in_sync[1:0], serial_in_pin};
		if (in_sync[1] == in_sync[2])
			rx_level <= in_sync[2];
	end
end

// apb slave, always zero wait state
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		size_ctrl         <= `RST_SIZE_CTRL;
		ext_control_b     <= `RST_EXT_CTRL;
		serial_control_b  <= `RST_CTRL_B;
		manchester_period <= `RST_PERIOD;
		low_tx            <= 8'h00;
		high_tx           <= 8'h00;
		ninth_bit_holder  <= 1'b0;
		prdata            <= 32'h0000_0000;
		pready            <= 1'b0;
		pslverr           <= 1'b0;
	end else begin
		pready  <= psel & ~penable;
		pslverr <= 1'b0;
		if (psel & ~penable & ~pwrite) begin
			case (paddr)
			`OFS_LOW_DATA:   prdata <= {24'h0, low_rx};
			`OFS_HIGH_DATA:  prdata <= {24'h0, high_rx};
			`OFS_SIZE_CTRL:  prdata <= {24'h0, size_ctrl};
			`OFS_EXT_CTRL:   prdata <= {24'h0, ext_control_b};
			`OFS_EXT_STATUS: prdata <= {27'h0, manchester_frame_error,
				long_frame_flag, 1'b0, stop_vals};
			`OFS_PERIOD:     prdata <= {16'h0, manchester_period};
			`OFS_CTRL_B:     prdata <= {23'h0, rx_bit17, serial_control_b};
			`OFS_STATUS_A:   prdata <= {24'h0, receive_complete_flag, 1'b0,
				~tx_full, level_frame_error, overrun, parity_err, 2'b00};
			default: begin
				prdata  <= 32'h0000_0000;
				pslverr <= 1'b1;
			end
			endcase
		end
		if (wr & pready) begin
			case (paddr)
			`OFS_LOW_DATA:  low_tx <= pwdata[7:0];
			`OFS_HIGH_DATA: if (ext_on) high_tx <= pwdata[7:0];
			`OFS_SIZE_CTRL: if (ext_on) size_ctrl <= pwdata[7:0];
			`OFS_EXT_CTRL:  ext_control_b <= pwdata[7:0];
			`OFS_PERIOD:    manchester_period <= pwdata[15:0];
			`OFS_CTRL_B: begin
				serial_control_b <= pwdata[7:0];
				ninth_bit_holder <= pwdata[8];
			end
			default: ;
			endcase
		end
	end
end

wire low_write = wr & pready & (paddr == `OFS_LOW_DATA);
wire low_read  = rd & pready & (paddr == `OFS_LOW_DATA);
wire tx_busy   = tx_full | (tx_state != TX_IDLE);

// transmitter
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		tx_state       <= TX_IDLE;
		tx_shift       <= 17'h00000;
		tx_left        <= 5'd0;
		tx_parity      <= 1'b0;
		tx_par_phase   <= 1'b0;
		tx_stop_left   <= 2'd0;
		tx_cnt         <= 16'h0000;
		tx_full        <= 1'b0;
		tx_active_en   <= 1'b0;
		serial_out_pin <= 1'b1;
		serial_out_en  <= 1'b0;
	end else begin
		// disable waits for shifter and buffer to drain
		if (serial_control_b[`CB_TX_ENABLE])
			tx_active_en <= 1'b1;
		else if (!tx_busy)
			tx_active_en <= 1'b0;
		serial_out_en <= tx_active_en;
		if (low_write && tx_active_en | serial_control_b[`CB_TX_ENABLE])
			tx_full <= 1'b1;
		tx_cnt <= tx_tick ? bit_time - 16'h0001 : tx_cnt - 16'h0001;
		case (tx_state)
		TX_IDLE: begin
			serial_out_pin <= 1'b1;
			if (tx_full && tx_active_en) begin
				tx_full   <= 1'b0;
				tx_shift  <= tx_word & tx_mask;
				tx_parity <= (^(tx_word & tx_mask)) ^ par_mode[0];
				tx_left   <= tx_len;
				tx_cnt    <= bit_time - 16'h0001;
				tx_state  <= TX_START;
			end
		end
		TX_START: begin
			// manchester start is a coded one
			serial_out_pin <= manch ? tx_half : 1'b0;
			if (tx_tick)
				tx_state <= TX_BITS;
		end
		TX_BITS: begin
			if (tx_par_phase)
				serial_out_pin <= tx_parity;
			else if (manch)
				serial_out_pin <= ~(tx_shift[0] ^ tx_half);
			else
				serial_out_pin <= tx_shift[0];
			if (tx_tick) begin
				if (tx_par_phase) begin
					tx_par_phase <= 1'b0;
					tx_stop_left <= ext_control_b[`EXT_TWO_STOP_TX] ?
						2'd2 : 2'd1;
					tx_state     <= TX_STOP;
				end else begin
					tx_shift <= {1'b0, tx_shift[16:1]};
					tx_left  <= tx_left - 5'd1;
					if (tx_left == 5'd1) begin
						tx_par_phase <= par_mode[1];
						tx_stop_left <= ext_control_b[`EXT_TWO_STOP_TX] ?
							2'd2 : 2'd1;
						if (!par_mode[1])
							tx_state <= TX_STOP;
					end
				end
			end
		end
		TX_STOP: begin
			serial_out_pin <= 1'b1;
			if (tx_tick) begin
				tx_stop_left <= tx_stop_left - 2'd1;
				if (tx_stop_left == 2'd1)
					tx_state <= TX_IDLE;
			end
		end
		default: tx_state <= TX_IDLE;
		endcase
	end
end

// receiver: manchester decoder with up/down edge counter
wire rx_edge = (rx_level != dec_prev);
// half_cnt holds twice the captured half count; window opens at a quarter of half_cnt
wire in_window = dec_down ? 1'b0 : (dec_cnt >= half_cnt[15:2]);
wire overflow = (dec_cnt >= manchester_period);
wire [16:0] rx_ordered = ext_control_b[`EXT_MSB_FIRST] ?
	rx_shift : (rx_shift >> (5'd17 - rx_got));

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rx_state               <= RX_HUNT;
		rx_shift               <= 17'h00000;
		rx_got                 <= 5'd0;
		dec_cnt                <= 16'h0000;
		half_cnt               <= 16'h0000;
		dec_down               <= 1'b0;
		dec_prev               <= 1'b1;
		rx_parity              <= 1'b0;
		rx_stop_idx            <= 2'd0;
		low_rx                 <= 8'h00;
		high_rx                <= 8'h00;
		rx_bit17               <= 1'b0;
		manchester_frame_error <= 1'b0;
		long_frame_flag        <= 1'b0;
		level_frame_error      <= 1'b0;
		overrun                <= 1'b0;
		parity_err             <= 1'b0;
		stop_vals              <= 2'b00;
		receive_complete_flag  <= 1'b0;
	end else begin
		dec_prev <= rx_level;
		// reading the low byte clears; a new completion in the same cycle wins
		if (low_read)
			receive_complete_flag <= 1'b0;
		dec_cnt <= dec_down ? dec_cnt - 16'h0001 : dec_cnt + 16'h0001;
		if (dec_down && dec_cnt == 16'h0001)
			dec_down <= 1'b0;
		if (!dec_on) begin
			rx_state <= RX_HUNT;
			dec_cnt  <= 16'h0000;
			dec_down <= 1'b0;
		end else case (rx_state)
		RX_HUNT: begin
			// start bit: any rising edge is taken as its mid-bit edge, no window check
			if (rx_edge && rx_level) begin
				half_cnt <= manchester_period;
				dec_cnt  <= manchester_period >> 1;
				dec_down <= 1'b1;
				rx_got   <= 5'd0;
				rx_shift <= 17'h00000;
				rx_state <= RX_BITS;
			end
		end
		RX_BITS: begin
			if (rx_edge && in_window) begin
				half_cnt <= dec_cnt << 1;
				dec_cnt  <= dec_cnt;
				dec_down <= 1'b1;
				rx_got   <= rx_got + 5'd1;
				if (ext_control_b[`EXT_MSB_FIRST])
					rx_shift <= {rx_shift[15:0], rx_level};
				else
					rx_shift <= {rx_level, rx_shift[16:1]};
				if (rx_got + 5'd1 == rx_len)
					rx_state <= RX_STOP;
			end else if (!dec_down && overflow) begin
				if (long_mode && rx_got == 5'd16) begin
					rx_state    <= RX_STOP; // no 17th edge: plain 16
					rx_stop_idx <= 2'd1;
				end else begin
					// frame error: flag, complete, re-hunt
					manchester_frame_error <= 1'b1;
					receive_complete_flag  <= 1'b1;
					rx_state               <= RX_HUNT;
				end
			end
		end
		RX_STOP: begin
			if (!dec_down && dec_cnt >= half_cnt[15:1]) begin
				stop_vals   <= {rx_level, stop_vals[1]};
				rx_stop_idx <= rx_stop_idx + 2'd1;
				dec_cnt     <= 16'h0000;
				if (rx_stop_idx != 2'd0 ||
					!ext_control_b[`EXT_TWO_STOP_RX]) begin
					overrun                <= receive_complete_flag & ~low_read;
					long_frame_flag        <= (rx_got == 5'd17);
					manchester_frame_error <= 1'b0;
					{rx_bit17, high_rx, low_rx} <= rx_ordered;
					receive_complete_flag  <= 1'b1;
					rx_stop_idx            <= 2'd0;
					rx_state               <= RX_HUNT;
				end
			end
		end
		default: rx_state <= RX_HUNT;
		endcase
	end
end
endmodule // ext_serial_codec

// ### hw/ext_serial_regs.vh
// register offsets, fields and reset values of the extended serial codec
`ifndef EXT_SERIAL_REGS_VH
`define EXT_SERIAL_REGS_VH
`define OFS_LOW_DATA    12'h000
`define OFS_HIGH_DATA   12'h004
`define OFS_SIZE_CTRL   12'h008
`define OFS_EXT_CTRL    12'h00C
`define OFS_EXT_STATUS  12'h010
`define OFS_PERIOD      12'h014
`define OFS_CTRL_B      12'h018
`define OFS_STATUS_A    12'h01C
`define OFS_PERIOD_LOW  12'h020
`define OFS_PERIOD_HIGH 12'h024
`define RST_SIZE_CTRL   8'h33
`define RST_EXT_CTRL    8'h00
`define RST_CTRL_B      8'h00
`define RST_PERIOD      16'h0010
// ext_control_b fields
`define EXT_ENABLE      0
`define EXT_MANCHESTER  1
`define EXT_MSB_FIRST   2
`define EXT_TWO_STOP_RX 3
`define EXT_TWO_STOP_TX 4
`define EXT_LONG_MODE   5
// serial_control_b fields
`define CB_RX_ENABLE    4
`define CB_TX_ENABLE    3
`define CB_PAR_LO       0
`define CB_PAR_HI       1
`define CB_DOUBLE_SPEED 2
// status fields
`define ST_RX_COMPLETE  7
`define ST_TX_EMPTY     5
`define ST_LEVEL_FE     4
`define ST_OVERRUN      3
`define ST_PARITY_ERR   2
`define EST_MAN_FE      4
`define EST_LONG_FRAME  3
`define EST_STOP2       1
`define EST_STOP1       0
`define SYNC_RESET      3'h0
`endif

// ### tb/ext_serial_monitor.sv
// port assertions for the extended serial codec
`timescale 1ns/100ps
`include "ext_serial_regs.vh"
module ext_serial_monitor (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        serial_out_pin,
	input wire        serial_out_en,
	input wire        receive_complete_flag
);
	logic       man;
	logic [4:0] lo;
	logic [4:0] hi;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// mode is learnt from ext control writes seen on the bus
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			man <= 1'b0;
			lo  <= 5'h00;
			hi  <= 5'h00;
		end else begin
			if (psel && penable && pready && pwrite && paddr == `OFS_EXT_CTRL)
				man <= pwdata[0] & pwdata[1];
			lo <= serial_out_pin ? 5'h00 : lo + {4'h0, lo != 5'h1F};
			hi <= !serial_out_pin ? 5'h00 : hi + {4'h0, hi != 5'h1F};
		end
	end
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error response");
	a_idle_line: assert property (!serial_out_en |-> serial_out_pin)
		else $error("line not idle high");
	a_disable_idle: assert property ($fell(serial_out_en) |->
		serial_out_pin && $past(serial_out_pin, 4))
		else $error("transmitter released mid frame");
	// only holds for the 8 clock bit time the bench programs
	a_start_half: assert property (man && serial_out_en && hi > 5'd8 &&
		$fell(serial_out_pin) |-> !serial_out_pin[*4] ##1 serial_out_pin)
		else $error("start bit halves wrong");
	a_low_run: assert property (man && serial_out_en |-> lo <= 5'd8)
		else $error("low run too long");
	a_flag_clear: assert property ($fell(receive_complete_flag) |->
		$past(psel && penable && !pwrite && paddr == `OFS_LOW_DATA))
		else $error("flag cleared without read");
endmodule // ext_serial_monitor
bind ext_serial_codec ext_serial_monitor ext_serial_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
	.serial_out_en(serial_out_en),
	.receive_complete_flag(receive_complete_flag));

// ### tb/remote_line.sv
// far side manchester transceiver model
`timescale 1ns/100ps
module remote_line #(
	parameter P = 8
) (
	input  wire pclk,
	input  wire line_in,
	output reg  line_out
);
	initial line_out = 1'b1;
	task automatic half(input logic v);
		line_out <= v;
		repeat (P/2) @(posedge pclk);
	endtask
	// gap names a bit sent without its mid edge
	task automatic send(input logic [16:0] d, input int n,
		input logic msb, input int gap);
		int   i;
		logic b;
		half(1'b0);
		half(1'b1);
		for (i = 0; i < n; i++) begin
			b = msb ? d[n-1-i] : d[i];
			half(i == gap ? b : !b);
			half(b);
		end
		repeat (4) half(1'b1);
	endtask
	// samples each half a quarter bit in, on the quiet clock edge
	task automatic take(input int n, output logic [16:0] d,
		output logic ok);
		int   i;
		logic a;
		d = 17'h0;
		ok = 1'b1;
		@(negedge line_in);
		repeat (P/4) @(negedge pclk);
		for (i = 0; i <= n; i++) begin
			a = line_in;
			repeat (P/2) @(negedge pclk);
			if (i > 0) d[i-1] = line_in;
			else ok = line_in;
			if (a == line_in) ok = 1'b0;
			repeat (P/2) @(negedge pclk);
		end
		if (!line_in) ok = 1'b0;
	endtask
endmodule // remote_line

// ### tb/tb_ext_serial_codec.sv
// self-checking bench for the extended serial codec
`timescale 1ns/100ps
`include "ext_serial_regs.vh"
module tb_ext_serial_codec;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr, rx_line, tx_line, tx_en, rx_done;
	logic [31:0] rd;
	logic        err;
	logic [16:0] d;
	logic        ok;
	int          i;
	int          n_errors = 0;
	int          comparisons = 0;
	logic [7:0]  t_ext [4] = '{8'h03, 8'h07, 8'h03, 8'h23};
	logic [7:0]  t_siz [4] = '{8'h33, 8'h33, 8'h38, 8'h3B};
	logic [16:0] t_dat [4] = '{17'hA5, 17'h3C, 17'h1ABC, 17'h1ABCD};
	int          t_n   [4] = '{8, 8, 13, 17};
	always #25 pclk = ~pclk;
	ext_serial_codec ext_serial_codec_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(rx_line), .serial_out_pin(tx_line),
		.serial_out_en(tx_en), .receive_complete_flag(rx_done));
	remote_line remote_line_inst (.pclk(pclk), .line_in(tx_line),
		.line_out(rx_line));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1) n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic wait_flag();
		int t;
		for (t = 0; t < 400 && rx_done !== 1'b1; t++) @(posedge pclk);
		if (rx_done !== 1'b1) n_errors++;
	endtask
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`OFS_SIZE_CTRL, 32'h33);
		rchk(`OFS_PERIOD, 32'h10);
		rchk(`OFS_CTRL_B, 32'h0);
		rchk(12'h0FC, 32'h0);
		check(32'(err), 32'h1);
		apb(1'b1, `OFS_SIZE_CTRL, 32'h7B);
		rchk(`OFS_SIZE_CTRL, 32'h33);
		apb(1'b1, `OFS_EXT_CTRL, 32'h03);
		apb(1'b1, `OFS_PERIOD, 32'h8);
		apb(1'b1, `OFS_SIZE_CTRL, 32'h73);
		apb(1'b1, `OFS_CTRL_B, 32'h08);
		fork
			remote_line_inst.take(9, d, ok);
			begin
				apb(1'b1, `OFS_HIGH_DATA, 32'h1);
				apb(1'b1, `OFS_LOW_DATA, 32'h5A);
				apb(1'b1, `OFS_CTRL_B, 32'h0);
				repeat (2) @(negedge pclk);
				check(32'(tx_en), 32'h1);
			end
		join
		check(32'(d), 32'h15A);
		check(32'(ok), 32'h1);
		repeat (30) @(negedge pclk);
		check(32'(tx_en), 32'h0);
		apb(1'b1, `OFS_SIZE_CTRL, 32'hF3);
		apb(1'b1, `OFS_CTRL_B, 32'h108);
		fork
			remote_line_inst.take(17, d, ok);
			begin
				apb(1'b1, `OFS_HIGH_DATA, 32'hAB);
				apb(1'b1, `OFS_LOW_DATA, 32'hCD);
			end
		join
		check(32'(d), 32'h1ABCD);
		check(32'(ok), 32'h1);
		remote_line_inst.send(17'h55, 8, 1'b0, -1);
		repeat (20) @(negedge pclk);
		check(32'(rx_done), 32'h0);
		apb(1'b1, `OFS_CTRL_B, 32'h10); // double speed stays off
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `OFS_EXT_CTRL, 32'(t_ext[i]));
			apb(1'b1, `OFS_SIZE_CTRL, 32'(t_siz[i]));
			remote_line_inst.send(t_dat[i], t_n[i], t_ext[i][2], -1);
			wait_flag();
			apb(1'b0, `OFS_EXT_STATUS, 32'h0);
			check(32'(rd[`EST_LONG_FRAME]), 32'(t_ext[i][5]));
			apb(1'b0, `OFS_CTRL_B, 32'h0);
			if (t_n[i] == 17) check(32'(rd[8]), 32'(t_dat[i][16]));
			rchk(`OFS_HIGH_DATA, 32'(t_dat[i][15:8]));
			rchk(`OFS_LOW_DATA, 32'(t_dat[i][7:0]));
			@(negedge pclk);
			check(32'(rx_done), 32'h0);
		end
		apb(1'b1, `OFS_EXT_CTRL, 32'h03);
		apb(1'b1, `OFS_SIZE_CTRL, 32'h33);
		// gap bit must be followed by a bit whose first half keeps its level
		remote_line_inst.send(17'hA5, 8, 1'b0, 2);
		wait_flag();
		apb(1'b0, `OFS_EXT_STATUS, 32'h0);
		check(32'(rd[`EST_MAN_FE]), 32'h1);
		apb(1'b0, `OFS_STATUS_A, 32'h0);
		check(32'(rd[`ST_RX_COMPLETE]), 32'h1);
		check(32'(rd[`ST_LEVEL_FE]), 32'h0);
		finish_test();
	end
endmodule // tb_ext_serial_codec
